// ### logic/adc_conversion_and_monitor_ctrl.sv
// Purpose: conversion sequencing, monitor routing, register file
// Assumes: clock is the master clock; filter sum is on this clock
// Notes: serial clock and start pin are sampled, not used as clocks
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_and_monitor_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial command port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // start pin
    input wire logic start_sync,
    // digital filter
    input wire logic [15:0] filter_sum,
    // conversion output
    output logic data_ready,
    output logic [15:0] conv_data,
    output logic sampling,
    // analog front end control
    output adc_ctrl_pkg::route_t route,
    output logic inputs_disconnected,
    output logic [2:0] gain_applied,
    output logic [1:0] amplifier_enable_field,
    output adc_ctrl_pkg::burnout_t burnout_level,
    output logic [3:0] excitation_magnitude_field,
    output logic [3:0] first_source_route_field,
    output logic [3:0] second_source_route_field,
    output logic [6:0] bias_connect_bits
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_DELAY = 2'b01, S_SAMPLE = 2'b10,
        S_OVERHEAD = 2'b11
    } conv_state_t;

    logic [4:0] addr;
    logic [7:0] wr_data, rd_data;
    logic wr_pulse, start_cmd;
    logic raw_valid;
    logic por_q, por_d;
    logic [7:0] init_q, init_d;
    logic [7:0] gain_q, gain_d, rate_q, rate_d, mag_q, mag_d;
    logic [7:0] rte_q, rte_d, bias_q, bias_d, sys_q, sys_d;
    logic [7:0] ofs_lo_q, ofs_lo_d, ofs_hi_q, ofs_hi_d;
    logic [7:0] fsc_lo_q, fsc_lo_d, fsc_hi_q, fsc_hi_d;
    logic ready, cfg_write;

    serial_cmd_port u_port (
        .clock(clock),
        .nrst(nrst),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .rd_data(rd_data),
        .addr(addr),
        .wr_data(wr_data),
        .wr_pulse(wr_pulse),
        .start_pulse(start_cmd)
    );

    result_compensator u_comp (
        .clock(clock),
        .nrst(nrst),
        .raw_valid(raw_valid),
        .raw(filter_sum),
        .offset({ofs_hi_q, ofs_lo_q}),
        .gain({fsc_hi_q, fsc_lo_q}),
        .res_valid(data_ready),
        .result(conv_data)
    );

    // register file and ready tracking

    // register writes and starts are ignored while the init count runs
    assign ready = (init_q == 8'h00);
    assign cfg_write = wr_pulse && ready &&
        addr >= adc_ctrl_pkg::ADDR_CFG_FIRST &&
        addr <= adc_ctrl_pkg::ADDR_CFG_LAST;

    always_comb begin
        por_d = por_q;
        init_d = ready ? init_q : init_q - 8'h01;
        {gain_d, rate_d, mag_d, rte_d, bias_d, sys_d} =
            {gain_q, rate_q, mag_q, rte_q, bias_q, sys_q};
        {ofs_lo_d, ofs_hi_d, fsc_lo_d, fsc_hi_d} =
            {ofs_lo_q, ofs_hi_q, fsc_lo_q, fsc_hi_q};
        if (wr_pulse && ready) begin
            unique case (addr)
                adc_ctrl_pkg::ADDR_STATUS: begin
                    if (!wr_data[adc_ctrl_pkg::POR_BIT]) begin
                        por_d = 1'b0;
                    end
                end
                adc_ctrl_pkg::ADDR_GAIN: gain_d = wr_data;
                adc_ctrl_pkg::ADDR_RATE: rate_d = wr_data;
                adc_ctrl_pkg::ADDR_EXC_MAG: mag_d = wr_data;
                adc_ctrl_pkg::ADDR_EXC_ROUTE: rte_d = wr_data;
                adc_ctrl_pkg::ADDR_BIAS: bias_d = wr_data;
                adc_ctrl_pkg::ADDR_SYSCTL: sys_d = wr_data;
                adc_ctrl_pkg::ADDR_OFS_LO: ofs_lo_d = wr_data;
                adc_ctrl_pkg::ADDR_OFS_HI: ofs_hi_d = wr_data;
                adc_ctrl_pkg::ADDR_FSC_LO: fsc_lo_d = wr_data;
                adc_ctrl_pkg::ADDR_FSC_HI: fsc_hi_d = wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            por_q <= 1'b1;
            init_q <= adc_ctrl_pkg::READY_INIT_CYCLES;
            gain_q <= adc_ctrl_pkg::GAIN_RST;
            rate_q <= adc_ctrl_pkg::RATE_RST;
            {mag_q, rte_q, bias_q, sys_q, ofs_lo_q, ofs_hi_q} <=
                {6{adc_ctrl_pkg::BYTE_RST}};
            {fsc_hi_q, fsc_lo_q} <= adc_ctrl_pkg::FSC_RST;
        end else begin
            por_q <= por_d;
            init_q <= init_d;
            {gain_q, rate_q, mag_q, rte_q, bias_q, sys_q} <=
                {gain_d, rate_d, mag_d, rte_d, bias_d, sys_d};
            {ofs_lo_q, ofs_hi_q, fsc_lo_q, fsc_hi_q} <=
                {ofs_lo_d, ofs_hi_d, fsc_lo_d, fsc_hi_d};
        end
    end

    always_comb begin
        rd_data = 8'h00;
        unique case (addr)
            adc_ctrl_pkg::ADDR_STATUS: begin
                rd_data[adc_ctrl_pkg::POR_BIT] = por_q;
                rd_data[adc_ctrl_pkg::NRDY_BIT] = ~ready;
            end
            adc_ctrl_pkg::ADDR_GAIN: rd_data = gain_q;
            adc_ctrl_pkg::ADDR_RATE: rd_data = rate_q;
            adc_ctrl_pkg::ADDR_EXC_MAG: rd_data = mag_q;
            adc_ctrl_pkg::ADDR_EXC_ROUTE: rd_data = rte_q;
            adc_ctrl_pkg::ADDR_BIAS: rd_data = bias_q;
            adc_ctrl_pkg::ADDR_SYSCTL: rd_data = sys_q;
            adc_ctrl_pkg::ADDR_OFS_LO: rd_data = ofs_lo_q;
            adc_ctrl_pkg::ADDR_OFS_HI: rd_data = ofs_hi_q;
            adc_ctrl_pkg::ADDR_FSC_LO: rd_data = fsc_lo_q;
            adc_ctrl_pkg::ADDR_FSC_HI: rd_data = fsc_hi_q;
            default: rd_data = 8'h00;
        endcase
    end

    // conversion sequencer
    conv_state_t state_q, state_d;
    logic [16:0] cnt_q, cnt_d;
    logic [3:0] div_q, div_d;
    logic first_q, first_d;
    logic pin_m, pin_s, pin_p;
    logic mod_tick, start_evt;
    logic [16:0] period, overhead;

    assign period = adc_ctrl_pkg::period_mods(rate_q[3:0]);
    // overhead is what the first result takes beyond delay and sampling
    assign overhead = adc_ctrl_pkg::first_mods(rate_q[3:0]) - period
        - adc_ctrl_pkg::CFG_DELAY_MODS;
    assign mod_tick = (div_q == adc_ctrl_pkg::MOD_DIV_LAST);
    assign start_evt = ready && (start_cmd || (pin_s && !pin_p) ||
        (cfg_write && state_q != S_IDLE));

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        first_d = first_q;
        raw_valid = 1'b0;
        div_d = div_q + 4'h1;
        if (start_evt) begin
            // a new start abandons any conversion in flight
            state_d = S_DELAY;
            cnt_d = adc_ctrl_pkg::CFG_DELAY_MODS - 17'h1;
            div_d = 4'h0;
            first_d = 1'b1;
        end else if (mod_tick) begin
            unique case (state_q)
                S_IDLE: ;
                S_DELAY: begin
                    cnt_d = cnt_q - 17'h1;
                    if (cnt_q == 17'h0) begin
                        state_d = S_SAMPLE;
                        cnt_d = period - 17'h1;
                    end
                end
                S_SAMPLE: begin
                    cnt_d = cnt_q - 17'h1;
                    if (cnt_q == 17'h0) begin
                        if (first_q) begin
                            state_d = S_OVERHEAD;
                            cnt_d = overhead - 17'h1;
                        end else begin
                            raw_valid = 1'b1;
                            cnt_d = period - 17'h1;
                        end
                    end
                end
                S_OVERHEAD: begin
                    cnt_d = cnt_q - 17'h1;
                    if (cnt_q == 17'h0) begin
                        raw_valid = 1'b1;
                        first_d = 1'b0;
                        cnt_d = period - 17'h1;
                        state_d = rate_q[adc_ctrl_pkg::MODE_BIT] ?
                            S_IDLE : S_SAMPLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            cnt_q <= 17'h0;
            div_q <= 4'h0;
            first_q <= 1'b0;
            {pin_m, pin_s, pin_p} <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            first_q <= first_d;
            {pin_m, pin_s, pin_p} <= {start_sync, pin_m, pin_s};
        end
    end

    // front end control, registered so outputs come from flops
    adc_ctrl_pkg::route_t route_q, route_d;
    adc_ctrl_pkg::burnout_t bo_q, bo_d;
    logic disc_q, disc_d, samp_q, samp_d;
    logic [2:0] gapp_q, gapp_d;

    always_comb begin
        route_d = adc_ctrl_pkg::ROUTE_INPUTS;
        bo_d = adc_ctrl_pkg::BO_OFF;
        disc_d = 1'b0;
        gapp_d = gain_q[2:0];
        samp_d = (state_d == S_SAMPLE);
        unique case (adc_ctrl_pkg::monitor_t'(sys_q[2:0]))
            adc_ctrl_pkg::MON_OFF: ;
            adc_ctrl_pkg::MON_MID: begin
                route_d = adc_ctrl_pkg::ROUTE_MIDSCALE;
                disc_d = 1'b1;
            end
            adc_ctrl_pkg::MON_TEMP: begin
                route_d = adc_ctrl_pkg::ROUTE_TEMP;
                disc_d = 1'b1;
            end
            adc_ctrl_pkg::MON_AVDD: begin
                route_d = adc_ctrl_pkg::ROUTE_AVDD4;
                disc_d = 1'b1;
                gapp_d = adc_ctrl_pkg::GAIN_UNITY;
            end
            adc_ctrl_pkg::MON_DVDD: begin
                route_d = adc_ctrl_pkg::ROUTE_DVDD4;
                disc_d = 1'b1;
                gapp_d = adc_ctrl_pkg::GAIN_UNITY;
            end
            adc_ctrl_pkg::MON_BO_LOW: bo_d = adc_ctrl_pkg::BO_0U2;
            adc_ctrl_pkg::MON_BO_MID: bo_d = adc_ctrl_pkg::BO_1U;
            adc_ctrl_pkg::MON_BO_HIGH: bo_d = adc_ctrl_pkg::BO_10U;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            route_q <= adc_ctrl_pkg::ROUTE_INPUTS;
            bo_q <= adc_ctrl_pkg::BO_OFF;
            {disc_q, samp_q} <= 2'b00;
            gapp_q <= adc_ctrl_pkg::GAIN_RST[2:0];
        end else begin
            route_q <= route_d;
            bo_q <= bo_d;
            {disc_q, samp_q} <= {disc_d, samp_d};
            gapp_q <= gapp_d;
        end
    end

    assign route = route_q;
    assign burnout_level = bo_q;
    assign inputs_disconnected = disc_q;
    assign gain_applied = gapp_q;
    assign sampling = samp_q;
    // amplifier enable passes through even for supply monitors
    assign amplifier_enable_field = gain_q[6:5];
    assign excitation_magnitude_field = mag_q[3:0];
    assign first_source_route_field = rte_q[3:0];
    assign second_source_route_field = rte_q[7:4];
    assign bias_connect_bits = bias_q[6:0];
endmodule: adc_conversion_and_monitor_ctrl
`default_nettype wire

// ### include/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: system clock is the converter master clock
// Notes: command codes and extra register offsets are local picks
// Notes on behaviour
// - start on pin rise or seventh command edge
// - configuration delay is 14 modulator periods of 16
// - delay after start, pin rise, writes 03h-07h
// - first result adds delay, sampling and overhead
// - later continuous results spaced one data period
// - overhead applies offset and gain compensation
// - monitor code 010 routes temperature sensor
// - temperature keeps gain, rate, reference; inputs off
// - codes 011/100 route analog/digital supply quarter
// - supply monitor disconnects inputs, forces gain one
// - supply monitor follows the amplifier enable field
// - codes 101-111 enable burn-out sources, three levels
// - 4-bit magnitude field at 06h sets both sources
// - each source route is a 4-bit field at 07h
// - per-input bits at 08h connect mid-supply bias
// - status register at 01h with reset and ready
// - bit 7 sets on reset, cleared writing zero
// - bit 6 shows not ready during register reset
package adc_ctrl_pkg;
    localparam logic [4:0] ADDR_STATUS = 5'h01,
        ADDR_GAIN = 5'h03,
        ADDR_RATE = 5'h04,
        ADDR_EXC_MAG = 5'h06,
        ADDR_EXC_ROUTE = 5'h07,
        ADDR_BIAS = 5'h08,
        ADDR_SYSCTL = 5'h09,
        ADDR_OFS_LO = 5'h0A,
        ADDR_OFS_HI = 5'h0B,
        ADDR_FSC_LO = 5'h0C,
        ADDR_FSC_HI = 5'h0D,
        ADDR_CFG_FIRST = 5'h03,
        ADDR_CFG_LAST = 5'h07;
    localparam logic [2:0] CMD_READ = 3'h1,
        CMD_WRITE = 3'h2;
    localparam int POR_BIT = 7,
        NRDY_BIT = 6,
        MODE_BIT = 5,
        FSC_SHIFT = 14;
    localparam logic [7:0] CMD_START = 8'h0A,
        GAIN_RST = 8'h00,
        RATE_RST = 8'h04,
        BYTE_RST = 8'h00,
        READY_INIT_CYCLES = 8'h20;
    localparam logic [15:0] FSC_RST = 16'h4000;
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic [3:0] MOD_DIV_LAST = 4'hF,
        BIT_SEVENTH = 4'h6,
        BIT_CMD_LAST = 4'h7,
        BIT_DATA_LAST = 4'hF;
    localparam logic [16:0] CFG_DELAY_MODS = 17'h0000E;
    typedef enum logic [2:0] {
        MON_OFF = 3'b000, MON_MID = 3'b001, MON_TEMP = 3'b010,
        MON_AVDD = 3'b011, MON_DVDD = 3'b100, MON_BO_LOW = 3'b101,
        MON_BO_MID = 3'b110, MON_BO_HIGH = 3'b111
    } monitor_t;
    typedef enum logic [2:0] {
        ROUTE_INPUTS = 3'b000, ROUTE_MIDSCALE = 3'b001,
        ROUTE_TEMP = 3'b010, ROUTE_AVDD4 = 3'b011, ROUTE_DVDD4 = 3'b100
    } route_t;
    typedef enum logic [1:0] {
        BO_OFF = 2'b00, BO_0U2 = 2'b01, BO_1U = 2'b10, BO_10U = 2'b11
    } burnout_t;
    // data period in modulator periods, per rate code
    function automatic logic [16:0] period_mods(input logic [3:0] rate);
        logic [16:0] p;
        unique case (rate)
            4'h0: p = 17'h19000;
            4'h1: p = 17'h0C800;
            4'h2: p = 17'h06400;
            4'h3: p = 17'h03C00;
            4'h4: p = 17'h03200;
            4'h5: p = 17'h01400;
            4'h6: p = 17'h010A8;
            4'h7: p = 17'h00A00;
            4'h8: p = 17'h00500;
            4'h9: p = 17'h00280;
            4'hA: p = 17'h00140;
            4'hB: p = 17'h00100;
            4'hC: p = 17'h00080;
            default: p = 17'h00040;
        endcase
        return p;
    endfunction: period_mods
    // first-result time in modulator periods, per rate code
    function automatic logic [16:0] first_mods(input logic [3:0] rate);
        logic [16:0] f;
        unique case (rate)
            4'h0: f = 17'h1968F;
            4'h1: f = 17'h0CE8F;
            4'h2: f = 17'h06A8F;
            4'h3: f = 17'h03C4F;
            4'h4: f = 17'h0388F;
            4'h5: f = 17'h0142E;
            4'h6: f = 17'h010F7;
            4'h7: f = 17'h00A36;
            4'h8: f = 17'h00536;
            4'h9: f = 17'h002B6;
            4'hA: f = 17'h00176;
            4'hB: f = 17'h00136;
            4'hC: f = 17'h000B6;
            default: f = 17'h00076;
        endcase
        return f;
    endfunction: first_mods
endpackage: adc_ctrl_pkg

// ### logic/serial_cmd_port.sv
// Purpose: serial command receiver and register read shifter
// Assumes: data sampled on falling serial clock, shifted on rising
// Notes: all pins pass two flops before use
`timescale 1ns/1ps
`default_nettype none
module serial_cmd_port (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // register side
    input wire logic [7:0] rd_data,
    output logic [4:0] addr,
    output logic [7:0] wr_data,
    output logic wr_pulse,
    output logic start_pulse
);
    logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, din_m, din_s;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, cmd_q, cmd_d, out_q, out_d, wd_q, wd_d;
    logic [4:0] addr_q, addr_d;
    logic load_q, load_d, wr_q, wr_d, st_q, st_d, dout_q, dout_d;
    logic fall, rise;

    assign fall = sclk_p & ~sclk_s;
    assign rise = ~sclk_p & sclk_s;

    always_comb begin
        logic [7:0] nx;
        nx = {sh_q[6:0], din_s};
        {cnt_d, sh_d, cmd_d, out_d, wd_d, addr_d} =
            {cnt_q, sh_q, cmd_q, out_q, wd_q, addr_q};
        {load_d, wr_d, st_d} = 3'b000;
        dout_d = dout_q;
        if (load_q) begin
            out_d = rd_data;
        end
        if (cs_s) begin
            cnt_d = 4'h0;
            dout_d = 1'b0;
        end else if (fall) begin
            sh_d = nx;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == adc_ctrl_pkg::BIT_SEVENTH &&
                nx[6:0] == adc_ctrl_pkg::CMD_START[7:1]) begin
                st_d = 1'b1;
            end
            if (cnt_q == adc_ctrl_pkg::BIT_CMD_LAST) begin
                cmd_d = nx;
                addr_d = nx[4:0];
                load_d = (nx[7:5] == adc_ctrl_pkg::CMD_READ);
            end
            if (cnt_q == adc_ctrl_pkg::BIT_DATA_LAST &&
                cmd_q[7:5] == adc_ctrl_pkg::CMD_WRITE) begin
                wr_d = 1'b1;
                wd_d = nx;
            end
        end else if (rise && cnt_q[3] &&
                     cmd_q[7:5] == adc_ctrl_pkg::CMD_READ) begin
            dout_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {sclk_m, sclk_s, sclk_p, din_m, din_s} <= 5'h00;
            {cs_m, cs_s} <= 2'h3;
            cnt_q <= 4'h0;
            {sh_q, cmd_q, out_q, wd_q} <= 32'h00000000;
            addr_q <= 5'h00;
            {load_q, wr_q, st_q, dout_q} <= 4'h0;
        end else begin
            {sclk_m, sclk_s, sclk_p} <= {sclk, sclk_m, sclk_s};
            {cs_m, cs_s, din_m, din_s} <= {cs_n, cs_m, din, din_m};
            cnt_q <= cnt_d;
            {sh_q, cmd_q, out_q, wd_q} <= {sh_d, cmd_d, out_d, wd_d};
            addr_q <= addr_d;
            {load_q, wr_q, st_q, dout_q} <= {load_d, wr_d, st_d, dout_d};
        end
    end

    assign dout = dout_q;
    assign addr = addr_q;
    assign wr_data = wd_q;
    assign wr_pulse = wr_q;
    assign start_pulse = st_q;
endmodule: serial_cmd_port
`default_nettype wire

// ### logic/result_compensator.sv
// Purpose: offset and gain correction of the filter sum
// Assumes: signed sum, signed offset, unsigned gain with 4000h unity
// Notes: one cycle of latency, result clipped to 16 bits
`timescale 1ns/1ps
`default_nettype none
module result_compensator (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // raw sum and corrections
    input wire logic raw_valid,
    input wire logic [15:0] raw,
    input wire logic [15:0] offset,
    input wire logic [15:0] gain,
    // corrected result
    output logic res_valid,
    output logic [15:0] result
);
    logic [15:0] res_q, res_d;
    logic val_q, val_d;

    always_comb begin
        logic signed [16:0] diff;
        logic signed [33:0] prod, scaled;
        diff = $signed({raw[15], raw}) - $signed({offset[15], offset});
        prod = diff * $signed({1'b0, gain});
        scaled = prod >>> adc_ctrl_pkg::FSC_SHIFT;
        val_d = raw_valid;
        res_d = res_q;
        if (raw_valid) begin
            // saturate rather than wrap on large gain factors
            if (scaled > 34'sd32767) begin
                res_d = 16'h7FFF;
            end else if (scaled < -34'sd32768) begin
                res_d = 16'h8000;
            end else begin
                res_d = scaled[15:0];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            res_q <= 16'h0000;
            val_q <= 1'b0;
        end else begin
            res_q <= res_d;
            val_q <= val_d;
        end
    end

    assign res_valid = val_q;
    assign result = res_q;
endmodule: result_compensator
`default_nettype wire

// ### testbench/adc_ctrl_props.sv
// Purpose: port checks for the converter control block
// Assumes: bound to the top module
// Notes: start timing assumes no config write in flight
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
    // watched ports
    input wire logic clock,
    input wire logic nrst,
    input wire logic start_sync,
    input wire logic sampling,
    input wire logic data_ready,
    input wire logic [15:0] conv_data,
    input wire adc_ctrl_pkg::route_t route,
    input wire logic inputs_disconnected,
    input wire logic [2:0] gain_applied,
    input wire adc_ctrl_pkg::burnout_t burnout_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_temp_inputs_off: assert property (
        route == adc_ctrl_pkg::ROUTE_TEMP |-> inputs_disconnected)
        else $error("temp inputs on");
    a_supply_gain_one: assert property (
        route inside {adc_ctrl_pkg::ROUTE_AVDD4, adc_ctrl_pkg::ROUTE_DVDD4}
        |-> gain_applied == adc_ctrl_pkg::GAIN_UNITY && inputs_disconnected)
        else $error("supply gain");
    a_normal_route_clean: assert property (
        route == adc_ctrl_pkg::ROUTE_INPUTS |-> !inputs_disconnected)
        else $error("normal inputs off");
    a_burnout_on_inputs: assert property (
        burnout_level != adc_ctrl_pkg::BO_OFF
        |-> route == adc_ctrl_pkg::ROUTE_INPUTS)
        else $error("burn-out routing");
    a_start_delay_hold: assert property (
        $rose(start_sync) |-> ##6 (!sampling) [*8])
        else $error("early sampling");
    a_start_then_sample: assert property (
        $rose(start_sync) |-> ##[224:232] $rose(sampling))
        else $error("no sampling");
    a_result_holds: assert property (
        !data_ready |-> $stable(conv_data))
        else $error("result moved");
    a_ready_pulse_gap: assert property (
        data_ready |=> (!data_ready) [*8])
        else $error("results too close");
endmodule: adc_ctrl_props
`default_nettype wire

// ### testbench/serial_host.sv
// Purpose: host side of the serial port and start pin
// Assumes: clock idles low, data set on rising, taken on falling
// Notes: data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    // clock
    input wire logic clock,
    // pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    output logic start_sync,
    input wire logic dout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        start_sync = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask: tick
    // dout taken late in the low half
    task automatic frame(input logic [15:0] w, input int n,
        output logic [7:0] r);
        r = 8'h00;
        cs_n = 1'b0;
        tick(4);
        for (int i = 15; i > 15 - n; i--) begin
            sclk = 1'b1;
            din = w[i];
            tick(4);
            sclk = 1'b0;
            tick(4);
            if (i < 8) r = {r[6:0], dout};
        end
        cs_n = 1'b1;
        din = ~din;
        tick(4);
    endtask: frame
    task automatic pin_start;
        start_sync = 1'b1;
    endtask: pin_start
endmodule: serial_host
`default_nettype wire

// ### testbench/test_adc_conversion_and_monitor_ctrl.sv
// Purpose: self-checking bench for the converter control block
// Assumes: rate code 13, so a data period is 1024 clocks
// Notes: windows allow a few clocks of pin synchronising
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_and_monitor_ctrl;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, din, dout, start_sync, data_ready, sampling;
    logic [15:0] filter_sum = 16'h1234;
    logic [15:0] conv_data;
    adc_ctrl_pkg::route_t route;
    adc_ctrl_pkg::burnout_t burnout_level;
    logic inputs_disconnected;
    logic [2:0] gain_applied;
    logic [1:0] amp_en;
    logic [3:0] mag, rt1, rt2;
    logic [6:0] bias;
    logic [7:0] r;
    int fails = 0;
    int n_tests = 0;
    int n;
    // per monitor code: route, burn-out level, inputs off
    logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h11, 6'h19, 6'h21, 6'h02,
        6'h04, 6'h06};
    always #25 clock = ~clock;
    adc_conversion_and_monitor_ctrl adc_conversion_and_monitor_ctrl_inst (
        .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .start_sync(start_sync), .filter_sum(filter_sum),
        .data_ready(data_ready), .conv_data(conv_data), .sampling(sampling),
        .route(route), .inputs_disconnected(inputs_disconnected),
        .gain_applied(gain_applied), .amplifier_enable_field(amp_en),
        .burnout_level(burnout_level), .excitation_magnitude_field(mag),
        .first_source_route_field(rt1), .second_source_route_field(rt2),
        .bias_connect_bits(bias));
    serial_host serial_host_inst (.clock(clock), .sclk(sclk), .cs_n(cs_n),
        .din(din), .start_sync(start_sync), .dout(dout));
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask: chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        serial_host_inst.frame({adc_ctrl_pkg::CMD_WRITE, a, d}, 16, r);
        serial_host_inst.tick(8);
    endtask: wr
    task automatic rd(input logic [4:0] a);
        serial_host_inst.frame({adc_ctrl_pkg::CMD_READ, a, 8'h00}, 16, r);
    endtask: rd
    // bounded: a miss counts 3000
    task automatic wait_dr;
        n = 0;
        do begin
            serial_host_inst.tick(1);
            n++;
        end while (data_ready !== 1'b1 && n < 3000);
    endtask: wait_dr
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask: end_sim
    initial begin
        #(50 * 40000);
        fails++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clock);
        #2 nrst = 1'b1;
        serial_host_inst.tick(60);
        rd(adc_ctrl_pkg::ADDR_STATUS);
        chk("status", 16'h0002, 16'(r[7:6]));
        wr(adc_ctrl_pkg::ADDR_STATUS, 8'h00);
        rd(adc_ctrl_pkg::ADDR_STATUS);
        chk("reset flag", 16'h0000, 16'(r[7]));
        wr(adc_ctrl_pkg::ADDR_GAIN, 8'h22);
        chk("amp enable", 16'h0001, 16'(amp_en));
        for (int i = 0; i < 8; i++) begin
            wr(adc_ctrl_pkg::ADDR_SYSCTL, 8'(i));
            chk("route", 16'(rows[i][5:3]), 16'(route));
            chk("burnout", 16'(rows[i][2:1]), 16'(burnout_level));
            chk("inputs off", 16'(rows[i][0]), 16'(inputs_disconnected));
            chk("gain", (i == 3 || i == 4) ? 16'h0 : 16'h2,
                16'(gain_applied));
        end
        wr(adc_ctrl_pkg::ADDR_SYSCTL, 8'h00);
        $display("test monitor done");
        wr(adc_ctrl_pkg::ADDR_EXC_MAG, 8'hA5);
        wr(adc_ctrl_pkg::ADDR_EXC_ROUTE, 8'h3A);
        wr(adc_ctrl_pkg::ADDR_BIAS, 8'h7F);
        chk("magnitude", 16'h0005, 16'(mag));
        chk("routes", 16'h003A, 16'({rt2, rt1}));
        chk("bias", 16'h007F, 16'(bias));
        wr(adc_ctrl_pkg::ADDR_RATE, 8'h0D);
        serial_host_inst.tick(2000);
        serial_host_inst.pin_start();
        wait_dr();
        chk("first time", 16'h1, 16'(n >= 1888 && n <= 1894));
        chk("result", 16'h1234, conv_data);
        wait_dr();
        chk("period", 16'(1024), 16'(n));
        wr(adc_ctrl_pkg::ADDR_OFS_LO, 8'h01);
        wait_dr();
        wait_dr();
        chk("offset", 16'h1233, conv_data);
        $display("test continuous done");
        wr(adc_ctrl_pkg::ADDR_RATE, 8'h2D);
        wait_dr();
        serial_host_inst.frame({adc_ctrl_pkg::CMD_START, 8'h00}, 8, r);
        wait_dr();
        chk("cmd start", 16'h1, 16'(n >= 1876 && n <= 1884));
        serial_host_inst.frame({adc_ctrl_pkg::CMD_START, 8'h00}, 8, r);
        serial_host_inst.tick(500);
        wr(adc_ctrl_pkg::ADDR_GAIN, 8'h22);
        wait_dr();
        chk("restart", 16'h1, 16'(n >= 1876 && n <= 1886));
        wait_dr();
        chk("single shot", 16'(3000), 16'(n));
        $display("test single shot done");
        end_sim();
    end
endmodule: test_adc_conversion_and_monitor_ctrl
bind adc_conversion_and_monitor_ctrl adc_ctrl_props adc_ctrl_props_inst (
    .clock(clock), .nrst(nrst), .start_sync(start_sync),
    .sampling(sampling), .data_ready(data_ready), .conv_data(conv_data),
    .route(route), .inputs_disconnected(inputs_disconnected),
    .gain_applied(gain_applied), .burnout_level(burnout_level));
`default_nettype wire
